// file: design/lsa_acc_mem.sv
// accumulator file: one write port, two registered read ports
`timescale 1ns/10ps
module lsa_acc_mem
    import lsa_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr_a,
    input wire logic [$clog2(DEPTH)-1:0] raddr_b,
    output logic [WIDTH-1:0] rdata_a,
    output logic [WIDTH-1:0] rdata_b
);

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("lsa_acc_mem: bad size");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // contents are data, not control, so no reset is spent on them
    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end

endmodule // lsa_acc_mem

// file: design/lsa_shifter.sv
// barrel shifter: one word into a 32-bit product pair
`timescale 1ns/10ps
module lsa_shifter
    import lsa_pkg::*;
(
    input wire logic [DW-1:0] src,
    input wire logic [SVW-1:0] count,
    input wire logic ext,
    input wire logic [DW-1:0] cin,
    output logic [DW-1:0] low,
    output logic [DW-1:0] high
);

    // =========================================
    // shift
    wire logic [2*DW-1:0] wide_in = {{DW{ext & src[DW-1]}}, src};
    wire logic [2*DW-1:0] wide = wide_in << count;

    // bits pushed out of the lower word fill the vacated low bits
    assign low = wide[DW-1:0] | cin;
    assign high = wide[2*DW-1:DW];

endmodule // lsa_shifter

// file: design/lsa_top.sv
// left shift accumulate datapath with its register port
//
// Summary of operation
// - single shift: dest gets source shifted left one, low bit zero
// - next-accumulator modifier steps the pointer before any access
// - every operation updates overflow, sign, zero and carry flags
// - string single shift: bit shifted out enters the next word
// - string single shift writes every word of the destination string
// - shift word by shift value into 32 bits, zero fill low bits
// - upper half to product high, lower half added to destination
// - bits shifted out of a word are carried into the next word
// - memory source updates the tag flag from the word's tag bit
// - string shift-add walks the whole string, carrying shifted bits
// - string to product: only the top 16 bits reach product high
// - string to product writes no accumulator, drops low half
// - string to product under repeat uses string length plus two
// - extend sign mode lives at status bit 0
`timescale 1ns/10ps
module lsa_top
    import lsa_pkg::*;
#(
    parameter int NACC = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire lsa_cmd_s cmd,
    output logic busy,
    output logic done,
    input wire logic [3:0] bus_addr,
    input wire logic [DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [DW-1:0] bus_rdata,
    output logic mem_rd,
    output logic [DW-1:0] mem_addr,
    input wire logic [DW-1:0] mem_rdata,
    input wire logic mem_tag
);

    initial begin
        if (NACC != (1 << AW)) begin
            $error("lsa_top: NACC must match the index width");
        end
    end

    // =========================================
    // state and registers
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD,
        ST_WT,
        ST_EX
    } lsa_state_e;

    lsa_state_e state_reg;
    lsa_state_e state_next;
    lsa_cmd_s cmd_reg;
    logic [CW-1:0] idx_reg;
    logic [CW-1:0] last_reg;
    logic [DW-1:0] carry_reg;
    logic acarry_reg;
    logic zacc_reg;
    lsa_flags_s flags_reg;
    logic [SVW-1:0] sv_reg;
    logic xm_reg;
    logic [DW-1:0] ph_reg;
    logic [AW-1:0] ap_reg;
    logic [DW-1:0] ptr_reg;
    logic busy_reg;
    logic done_reg;
    logic mem_rd_reg;
    logic [DW-1:0] rdata_reg;

    // =========================================
    // helpers
    function automatic logic [AW-1:0] acc_idx(
        input logic [AW-1:0] ap,
        input logic off,
        input logic [CW-1:0] i
    );
        acc_idx = ap + (off ? ACC_OFFS : '0) + i[AW-1:0];
    endfunction

    function automatic logic is_string(input lsa_op_e op);
        is_string = (op == OP_SINGLE_BIT_STRING_SHIFT) ||
            (op == OP_STRING_SHIFT_ADD_LOW_PRODUCT) ||
            (op == OP_STRING_SHIFT_TO_PRODUCT);
    endfunction

    // =========================================
    // command decode
    wire logic accept = cmd_valid && (state_reg == ST_IDLE);
    wire logic cmd_str = is_string(cmd.op);
    wire logic cmd_tp = (cmd.op == OP_STRING_SHIFT_TO_PRODUCT);
    wire logic [CW-1:0] slen_w = {1'b0, cmd.slen};
    wire logic [CW-1:0] last_w = !cmd_str ? '0 :
        (cmd_tp && cmd.repeat_instruction) ? slen_w + 5'h01 : slen_w;

    wire logic [AW-1:0] ap_inc = ap_reg + 4'h1;
    wire logic [AW-1:0] ap_dec = ap_reg - 4'h1;
    wire logic [AW-1:0] ap_pre = (cmd.next_acc == NEXT_INC) ? ap_inc :
        (cmd.next_acc == NEXT_DEC) ? ap_dec : ap_reg;

    // =========================================
    // operation decode for the command in flight
    wire lsa_op_e op = cmd_reg.op;
    wire logic op_single = (op == OP_SINGLE_BIT_ACC_SHIFT) ||
        (op == OP_SINGLE_BIT_STRING_SHIFT);
    wire logic op_tp = (op == OP_STRING_SHIFT_TO_PRODUCT);
    wire logic is_last = (idx_reg == last_reg);
    wire logic in_ex = (state_reg == ST_EX);

    // =========================================
    // accumulator file
    wire logic [AW-1:0] src_idx =
        acc_idx(ap_reg, cmd_reg.src_off, idx_reg);
    wire logic [AW-1:0] dst_idx =
        acc_idx(ap_reg, cmd_reg.dst_off, idx_reg);
    logic [DW-1:0] acc_a;
    logic [DW-1:0] acc_b;
    logic [DW-1:0] wr_data;
    wire logic acc_we = in_ex && !op_tp;

    lsa_acc_mem #(
        .WIDTH(DW),
        .DEPTH(NACC)
    ) u_acc (
        .clock(clock),
        .we(acc_we),
        .waddr(dst_idx),
        .wdata(wr_data),
        .raddr_a(src_idx),
        .raddr_b(dst_idx),
        .rdata_a(acc_a),
        .rdata_b(acc_b)
    );

    // =========================================
    // datapath
    wire logic [DW-1:0] src_word = cmd_reg.mem_src ? mem_rdata : acc_a;

    // the first word sees a zero carry, so the result low bit is zero
    wire logic [DW-1:0] sb_res = {src_word[DW-2:0], carry_reg[0]};
    wire logic sb_out = src_word[DW-1];

    // only the most significant word of a string may sign extend
    wire logic sh_ext = xm_reg && is_last;
    logic [DW-1:0] sh_low;
    logic [DW-1:0] sh_high;

    lsa_shifter u_shift (
        .src(src_word),
        .count(sv_reg),
        .ext(sh_ext),
        .cin(carry_reg),
        .low(sh_low),
        .high(sh_high)
    );

    wire logic [DW:0] sum = {1'b0, acc_b} + {1'b0, sh_low} +
        {{DW{1'b0}}, acarry_reg};
    wire logic sum_ovf = (acc_b[DW-1] == sh_low[DW-1]) &&
        (sum[DW-1] != acc_b[DW-1]);

    assign wr_data = op_single ? sb_res : sum[DW-1:0];

    // string to product takes sign from the top word's high half; zero also takes lower words' low halves
    wire logic [DW-1:0] flag_word = !op_tp ? wr_data :
        (is_last ? sh_high : sh_low);
    wire logic word_zero = (flag_word == '0);

    lsa_flags_s flags_new;
    assign flags_new.ovf = op_single ? (sb_out ^ src_word[DW-2]) :
        (op_tp ? 1'b0 : sum_ovf);
    assign flags_new.sign = flag_word[DW-1];
    assign flags_new.zero = zacc_reg && word_zero;
    assign flags_new.carry = op_single ? sb_out :
        (op_tp ? sh_high[DW-1] : sum[DW]);
    assign flags_new.tag = cmd_reg.mem_src ? mem_tag : flags_reg.tag;

    // =========================================
    // sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    state_next = ST_RD;
                end
            end
            ST_RD: state_next = ST_WT;
            ST_WT: state_next = ST_EX;
            ST_EX: begin
                state_next = is_last ? ST_IDLE : ST_RD;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // =========================================
    // command capture and word walk
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cmd_reg <= '0;
            idx_reg <= '0;
            last_reg <= '0;
        end else if (accept) begin
            cmd_reg <= cmd;
            idx_reg <= '0;
            last_reg <= last_w;
        end else if (in_ex && !is_last) begin
            idx_reg <= idx_reg + 5'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            carry_reg <= '0;
            acarry_reg <= 1'b0;
            zacc_reg <= 1'b1;
        end else if (accept) begin
            carry_reg <= '0;
            acarry_reg <= 1'b0;
            zacc_reg <= 1'b1;
        end else if (in_ex) begin
            carry_reg <= op_single ? {{DW-1{1'b0}}, sb_out} : sh_high;
            acarry_reg <= sum[DW];
            zacc_reg <= flags_new.zero;
        end
    end

    // =========================================
    // flags and product high
    always_ff @(posedge clock) begin
        if (!nrst) begin
            flags_reg <= '0;
            ph_reg <= PH_RST;
        end else if (in_ex && is_last) begin
            flags_reg <= flags_new;
            if (!op_single) begin
                ph_reg <= sh_high;
            end
        end
    end

    // =========================================
    // pointers
    wire logic bus_wr_ok = bus_wr && (state_reg == ST_IDLE) && !accept;
    wire logic ptr_step = in_ex && cmd_reg.mem_src && cmd_reg.post_inc;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ap_reg <= AP_RST;
        end else if (accept) begin
            ap_reg <= ap_pre;
        end else if (bus_wr_ok && bus_addr == ADDR_AP) begin
            ap_reg <= bus_wdata[AW-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ptr_reg <= PTR_RST;
        end else if (ptr_step) begin
            ptr_reg <= ptr_reg + PTR_STEP;
        end else if (bus_wr_ok && bus_addr == ADDR_PTR) begin
            ptr_reg <= bus_wdata;
        end
    end

    // =========================================
    // mode registers, written at any time
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sv_reg <= SV_RST;
            xm_reg <= XM_RST;
        end else if (bus_wr) begin
            if (bus_addr == ADDR_SV) begin
                sv_reg <= bus_wdata[SVW-1:0];
            end
            if (bus_addr == ADDR_STAT) begin
                xm_reg <= bus_wdata[XM_BIT];
            end
        end
    end

    // =========================================
    // register read
    logic [DW-1:0] stat_word;
    always_comb begin
        stat_word = '0;
        stat_word[XM_BIT] = xm_reg;
        stat_word[OF_BIT] = flags_reg.ovf;
        stat_word[SF_BIT] = flags_reg.sign;
        stat_word[ZF_BIT] = flags_reg.zero;
        stat_word[CF_BIT] = flags_reg.carry;
        stat_word[TF_BIT] = flags_reg.tag;
        stat_word[BUSY_BIT] = busy_reg;
    end

    wire logic [DW-1:0] rd_mux =
        (bus_addr == ADDR_SV) ? {{DW-SVW{1'b0}}, sv_reg} :
        (bus_addr == ADDR_STAT) ? stat_word :
        (bus_addr == ADDR_PH) ? ph_reg :
        (bus_addr == ADDR_AP) ? {{DW-AW{1'b0}}, ap_reg} :
        (bus_addr == ADDR_PTR) ? ptr_reg : '0;

    // =========================================
    // output registers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdata_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            mem_rd_reg <= 1'b0;
        end else begin
            rdata_reg <= bus_rd ? rd_mux : '0;
            busy_reg <= (state_next != ST_IDLE);
            done_reg <= in_ex && is_last;
            mem_rd_reg <= (state_reg == ST_RD) && cmd_reg.mem_src;
        end
    end

    assign bus_rdata = rdata_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign mem_rd = mem_rd_reg;
    assign mem_addr = ptr_reg;

endmodule // lsa_top

// file: shared/lsa_pkg.sv
// shared constants and types for the left shift accumulate unit
package lsa_pkg;

    // =========================================
    // widths
    localparam int DW = 16;
    localparam int AW = 4;
    localparam int SVW = 4;
    localparam int CW = 5;

    // =========================================
    // register offsets
    localparam logic [3:0] ADDR_SV = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h1;
    localparam logic [3:0] ADDR_PH = 4'h2;
    localparam logic [3:0] ADDR_AP = 4'h3;
    localparam logic [3:0] ADDR_PTR = 4'h4;

    // =========================================
    // status field positions
    localparam int XM_BIT = 0;
    localparam int OF_BIT = 4;
    localparam int SF_BIT = 5;
    localparam int ZF_BIT = 6;
    localparam int CF_BIT = 7;
    localparam int TF_BIT = 8;
    localparam int BUSY_BIT = 15;

    // =========================================
    // reset values and steps
    localparam logic [SVW-1:0] SV_RST = 4'h0;
    localparam logic XM_RST = 1'b0;
    localparam logic [AW-1:0] AP_RST = 4'h0;
    localparam logic [DW-1:0] PTR_RST = 16'h0000;
    localparam logic [DW-1:0] PH_RST = 16'h0000;
    localparam logic [DW-1:0] PTR_STEP = 16'h0002;
    localparam logic [AW-1:0] ACC_OFFS = 4'h8;

    // =========================================
    // types
    typedef enum logic [2:0] {
        OP_SINGLE_BIT_ACC_SHIFT,
        OP_SINGLE_BIT_STRING_SHIFT,
        OP_SHIFT_ADD_LOW_PRODUCT,
        OP_STRING_SHIFT_ADD_LOW_PRODUCT,
        OP_STRING_SHIFT_TO_PRODUCT
    } lsa_op_e;

    typedef enum logic [1:0] {
        NEXT_NONE,
        NEXT_INC,
        NEXT_DEC
    } lsa_next_e;

    typedef struct packed {
        lsa_op_e op;
        lsa_next_e next_acc;
        logic dst_off;
        logic src_off;
        logic mem_src;
        logic post_inc;
        logic [3:0] slen;
        logic repeat_instruction;
    } lsa_cmd_s;

    typedef struct packed {
        logic ovf;
        logic sign;
        logic zero;
        logic carry;
        logic tag;
    } lsa_flags_s;

endpackage

// file: testbench/left_shift_accumulate_unit_bench.sv
// self-checking bench for the left shift accumulate unit
`timescale 1ns/10ps
module left_shift_accumulate_unit_bench
    import lsa_pkg::*;
;
    logic clock, nrst, cmd_valid, busy, done, bus_wr, bus_rd, mem_rd;
    logic mem_tag, t, x, rd_d;
    lsa_cmd_s cmd;
    logic [3:0] bus_addr, s;
    logic [DW-1:0] bus_wdata, bus_rdata, mem_addr, mem_rdata, v, w, ptr;
    logic [31:0] p;
    logic [DW:0] q;
    logic [DW-1:0] exp_q[$];
    int err_count, tests_run, seed, n;

    lsa_top dut_u (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd(cmd), .busy(busy), .done(done), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_tag(mem_tag));

    // ====================
    // checking and verdict
    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] want);
        tests_run++;
        if (seen !== want) begin
            err_count++;
            $display("ERROR %0t: read %h expected %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict;
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ====================
    // drivers
    task automatic wr(input logic [3:0] a, input logic [DW-1:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [3:0] a, input logic [DW-1:0] e);
        exp_q.push_back(e);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        @(posedge clock);
    endtask

    task automatic run(input lsa_op_e op, input lsa_next_e nx, input logic ms,
        input logic [3:0] sl, input logic rp);
        cmd <= '{op, nx, 1'b0, 1'b0, ms, ms, sl, rp};
        cmd_valid <= 1'b1;
        @(posedge clock);
        cmd_valid <= 1'b0;
        for (n = 0; n < 60; n++) begin
            @(negedge clock);
            if (done === 1'b1) break;
        end
        check(DW'(done), 16'h0001);
        @(posedge clock);
    endtask

    // accumulators have no reset: sixteen single shifts flush one to zero
    task automatic clr;
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_AP, DW'(k));
            repeat (16) run(OP_SINGLE_BIT_ACC_SHIFT, NEXT_NONE, 1'b0, 4'h0, 1'b0);
        end
    endtask

    // one-word product at count 15 shows {0, acc[15:1]} of the pointed word
    task automatic peek(input logic [DW-1:0] e);
        wr(ADDR_STAT, 16'h0000);
        wr(ADDR_SV, 16'h000F);
        run(OP_STRING_SHIFT_TO_PRODUCT, NEXT_NONE, 1'b0, 4'h0, 1'b0);
        rd(ADDR_PH, e);
    endtask

    function automatic logic [DW-1:0] stf(input logic c, z, sg, o);
        return {7'h00, t, c, z, sg, o, 4'h0};
    endfunction

    // memory answers only in the cycle after a read; otherwise noise
    always @(posedge clock) begin
        mem_rdata <= mem_rd ? v : DW'($random(seed));
        mem_tag <= mem_rd ? t : ~mem_tag;
    end

    always @(posedge clock) begin
        if (rd_d) check(bus_rdata, exp_q.pop_front());
        rd_d <= bus_rd;
    end

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // a full run needs about 1200 cycles; 20000 means a hang
    initial begin
        #100000;
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        give_verdict();
    end

    // ====================
    // main sequence
    initial begin
        seed = 36539;
        {nrst, cmd_valid, bus_wr, bus_rd, rd_d, mem_tag, t} = 7'h00;
        cmd = '0;
        bus_addr = 4'h0;
        bus_wdata = 16'h0000;
        mem_rdata = 16'h0000;
        v = 16'h0000;
        ptr = 16'h0100;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rd(ADDR_SV, 16'h0000);
        rd(ADDR_STAT, 16'h0000);
        rd(ADDR_PH, 16'h0000);
        rd(ADDR_AP, 16'h0000);
        rd(4'hF, 16'h0000);
        wr(4'hF, 16'hFFFF);
        wr(ADDR_STAT, 16'hFFFF);
        rd(ADDR_STAT, 16'h0001);
        wr(ADDR_SV, 16'hFFFF);
        rd(ADDR_SV, 16'h000F);
        wr(ADDR_PTR, ptr);
        repeat (4) begin
            v = DW'($random(seed));
            t = 1'($random(seed));
            s = 4'($random(seed));
            x = 1'($random(seed));
            clr();
            wr(ADDR_AP, 16'h0000);
            wr(ADDR_STAT, 16'h0000);
            wr(ADDR_SV, 16'h0000);
            run(OP_SHIFT_ADD_LOW_PRODUCT, NEXT_NONE, 1'b1, 4'h0, 1'b0);
            ptr = ptr + PTR_STEP;
            rd(ADDR_PTR, ptr);
            rd(ADDR_STAT, stf(1'b0, v == 16'h0000, v[15], 1'b0));
            rd(ADDR_PH, 16'h0000);
            wr(ADDR_STAT, {15'h0000, x});
            wr(ADDR_SV, {12'h000, s});
            run(OP_STRING_SHIFT_TO_PRODUCT, NEXT_NONE, 1'b0, 4'h0, 1'b0);
            p = {{16{x & v[15]}}, v} << s;
            rd(ADDR_PH, p[31:16]);
            run(OP_STRING_SHIFT_TO_PRODUCT, NEXT_NONE, 1'b0, 4'h0, 1'b1);
            // second word is zero, so nothing leaves the top of the string
            rd(ADDR_PH, 16'h0000);
            peek({1'b0, v[15:1]});
            wr(ADDR_AP, 16'h0001);
            run(OP_SINGLE_BIT_ACC_SHIFT, NEXT_DEC, 1'b0, 4'h0, 1'b0);
            rd(ADDR_AP, 16'h0000);
            w = v << 1;
            rd(ADDR_STAT, stf(v[15], w == 16'h0000, v[14], v[15] ^ v[14]));
            peek({1'b0, v[14:0]});
            run(OP_SINGLE_BIT_STRING_SHIFT, NEXT_NONE, 1'b0, 4'h1, 1'b0);
            rd(ADDR_STAT, stf(1'b0, v[14:0] == 15'h0000, 1'b0, 1'b0));
            peek({1'b0, v[13:0], 1'b0});
            run(OP_SINGLE_BIT_ACC_SHIFT, NEXT_INC, 1'b0, 4'h0, 1'b0);
            rd(ADDR_AP, 16'h0001);
            peek({15'h0000, v[14]});
            // memory string at count s added onto acc0 and acc1
            wr(ADDR_AP, 16'h0000);
            wr(ADDR_SV, {12'h000, s});
            run(OP_STRING_SHIFT_ADD_LOW_PRODUCT, NEXT_NONE, 1'b1, 4'h1, 1'b0);
            ptr = ptr + PTR_STEP + PTR_STEP;
            p = {16'h0000, v} << s;
            q = {1'b0, v[13:0], 2'b00} + {1'b0, p[15:0]};
            w = {14'h0000, v[14], 1'b0} + (p[15:0] | p[31:16]) + DW'(q[DW]);
            rd(ADDR_PH, p[31:16]);
            wr(ADDR_AP, 16'h0001);
            peek({1'b0, w[15:1]});
        end
        give_verdict();
    end
endmodule // left_shift_accumulate_unit_bench

// file: testbench/lsa_top_chk.sv
// port checker for the left shift accumulate unit
`timescale 1ns/10ps
module lsa_top_chk
    import lsa_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire lsa_cmd_s cmd,
    input wire logic busy,
    input wire logic done,
    input wire logic mem_rd,
    input wire logic [DW-1:0] mem_addr
);
    // ====================
    // helper state captured at command acceptance
    wire logic accept;
    wire logic [4:0] words_next;
    logic [4:0] words_reg;
    logic [5:0] cnt_reg;
    logic pinc_reg;
    logic msrc_reg;

    assign accept = cmd_valid && !busy;
    assign words_next = (cmd.op == OP_SINGLE_BIT_ACC_SHIFT ||
        cmd.op == OP_SHIFT_ADD_LOW_PRODUCT) ? 5'h01 : 5'(cmd.slen) + 5'h01 +
        5'(cmd.op == OP_STRING_SHIFT_TO_PRODUCT && cmd.repeat_instruction);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            words_reg <= 5'h00;
            cnt_reg <= 6'h00;
            pinc_reg <= 1'b0;
            msrc_reg <= 1'b0;
        end else if (accept) begin
            words_reg <= words_next;
            cnt_reg <= 6'h00;
            pinc_reg <= cmd.post_inc;
            msrc_reg <= cmd.mem_src;
        end else if (busy) begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

    // ====================
    // assertions
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!nrst);

    accept_busy_a: assert property (accept |=> busy)
        else $error("accepted command did not raise busy");
    busy_cause_a: assert property ($rose(busy) |-> $past(accept))
        else $error("busy rose without an accepted command");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    busy_end_a: assert property ($fell(busy) |-> done)
        else $error("busy fell without done");
    word_count_a: assert property (done |-> cnt_reg == {1'b0, words_reg} * 6'h03)
        else $error("busy span does not match the word count");
    mem_pulse_a: assert property (mem_rd |=> !mem_rd)
        else $error("memory read strobe longer than one cycle");
    mem_src_a: assert property (mem_rd |-> busy && msrc_reg)
        else $error("memory read without a memory source command");
    ptr_step_a: assert property (mem_rd && pinc_reg |-> ##2
        mem_addr == $past(mem_addr, 2) + PTR_STEP)
        else $error("pointer did not advance by two after a word");

    string_done_c: cover property (done && words_reg > 5'h01);
    mem_inc_c: cover property (mem_rd && pinc_reg);
    rpt_cmd_c: cover property (accept && cmd.repeat_instruction &&
        cmd.op == OP_STRING_SHIFT_TO_PRODUCT);
endmodule // lsa_top_chk

bind lsa_top lsa_top_chk chk_u (.clock(clock), .nrst(nrst),
    .cmd_valid(cmd_valid), .cmd(cmd), .busy(busy), .done(done),
    .mem_rd(mem_rd), .mem_addr(mem_addr));
